/* design/opc_pkg.sv */
// package of constants for the otg power and pullup control block
package opc_pkg;
    localparam logic [7:0] LINE_CTRL_ADDR = 8'h10;
    localparam logic [7:0] BUS_CTRL_ADDR = 8'h11;
    localparam logic [7:0] STATUS_ADDR = 8'h13;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;
    localparam logic [7:0] LINE_CTRL_RST = 8'h00;
    localparam logic [7:0] BUS_CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam int SHUTDOWN_POS = 0;
    localparam int TIMED_PULSE_POS = 1;
    localparam int CONT_CHARGE_POS = 2;
    localparam int PUMP_DRIVE_POS = 3;
    localparam int DISCHARGE_POS = 4;
    localparam int AUTO_NEG_POS = 5;
    localparam int PU_ONE_POS = 4;
    localparam int PU_TWO_POS = 5;
    localparam int PD_PLUS_POS = 6;
    localparam int PD_MINUS_POS = 7;
    localparam int IDENT_STAT_POS = 3;
    localparam int HOST_NEG_STAT_POS = 4;
    localparam int PERI_NEG_STAT_POS = 5;
    localparam int HOST_NEG_IRQ_POS = 4;
    localparam int CLK_HZ = 10_000_000;
    localparam int CONNECT_MAX_US = 3000;
    localparam int MONITOR_DELAY_US = 25;
    localparam int PULSE_MS = 60;
    localparam int CONNECT_CYC = CONNECT_MAX_US * (CLK_HZ / 1_000_000);
    localparam int MONITOR_CYC =
        (MONITOR_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 20;
    typedef enum logic [1:0] {
        OPC_IDLE = 2'b00,
        OPC_WAIT = 2'b01,
        OPC_ARMED = 2'b11,
        OPC_DONE = 2'b10
    } opc_neg_st_t;
endpackage

/* design/opc_timer.sv */
// down counter that reports expiry
`timescale 1ns/1ps
module opc_timer #(
    parameter int W = 20
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    output logic zero_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = value_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign zero_o = (cnt_q == '0) && !load_i;
endmodule

/* design/opc_core.sv */
// otg bus power, pullup switching and automatic negotiation logic
`timescale 1ns/1ps
// Overview of operation
// - bus control bit0 one enters shutdown
// - shutdown turns off charger and comparators
// - registers and ident path work in shutdown
// - timed pulse bit gives one charge pulse
// - continuous charge bit holds current source on
// - drive bit switches the charge pump
// - discharge bit connects bus discharge resistor
// - autoconnect needs host ident and enable
// - autoresponse needs peripheral ident and enable
// - single ended zero connects pullup within 3ms
// - autoconnect sets host status and interrupt
// - clearing enable on host drops pullup
// - no automatic negotiation during shutdown
// - wait 25us, then reset on peer pullup
// - clearing enable on peripheral stops reset
// - pulse length meets the charge voltage limits
// - new pulse needs timed bit cleared, reset
// - pulsing inactive during shutdown
// - line control bits 4..7 drive switches
// - plus pullup wins over minus pullup
module opc_core
    import opc_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int CONNECT_CYCLES = CONNECT_CYC,
    parameter int MONITOR_CYCLES = MONITOR_CYC
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic role_ident_input_i,
    input wire logic dp_level_i,
    input wire logic dm_level_i,
    output logic role_ident_output_o,
    output logic charge_source_on_o,
    output logic comparators_on_o,
    output logic pump_drive_o,
    output logic supply_discharge_o,
    output logic plus_pullup_on_o,
    output logic minus_pullup_on_o,
    output logic plus_pulldown_on_o,
    output logic minus_pulldown_on_o,
    output logic bus_reset_drive_o,
    output logic host_neg_irq_o
);
    logic [7:0] line_q, line_d;
    logic [7:0] bus_q, bus_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic id_s1_q, id_s2_q, dp_s1_q, dp_s2_q, dm_s1_q, dm_s2_q;
    logic host_stat_q, host_stat_d, peri_stat_q, peri_stat_d;
    logic auto_pu_q, auto_pu_d, se0_q, se0_d;
    logic pulse_on_q, pulse_on_d, pulse_used_q, pulse_used_d;
    opc_neg_st_t st_q, st_d;
    logic shutdown, host_role, auto_en, host_auto, peri_auto;
    logic se0_seen, tmr_load, tmr_zero, pulse_load, pulse_zero;
    logic [CNT_W-1:0] tmr_val;
    logic out_cs, out_cmp, out_pump, out_dis, out_pup, out_mup;
    logic out_ppd, out_mpd, out_irq;

    assign shutdown = bus_q[SHUTDOWN_POS];
    assign host_role = !id_s2_q;
    assign auto_en = bus_q[AUTO_NEG_POS];
    assign host_auto = host_role && auto_en
        && !shutdown;
    assign peri_auto = !host_role && auto_en && !shutdown;
    assign se0_seen = !dp_s2_q && !dm_s2_q;

    // registers: writes work in any mode and shutdown keeps contents
    always_comb begin
        line_d = line_q;
        bus_d = bus_q;
        mask_d = mask_q;
        rdata_d = rdata_q;
        if (reg_wr_i) begin
            case (reg_addr_i)
                LINE_CTRL_ADDR: line_d = reg_wdata_i;
                BUS_CTRL_ADDR: bus_d = reg_wdata_i;
                IRQ_MASK_ADDR: mask_d = reg_wdata_i;
                default: line_d = line_q;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                LINE_CTRL_ADDR: rdata_d = line_q;
                BUS_CTRL_ADDR: rdata_d = bus_q;
                IRQ_MASK_ADDR: rdata_d = mask_q;
                STATUS_ADDR: begin
                    rdata_d = 8'h00;
                    rdata_d[IDENT_STAT_POS] = id_s2_q;
                    rdata_d[HOST_NEG_STAT_POS] = host_stat_q;
                    rdata_d[PERI_NEG_STAT_POS] = peri_stat_q;
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // negotiation state machine shares one timer
    always_comb begin
        st_d = st_q;
        auto_pu_d = auto_pu_q;
        se0_d = se0_q;
        host_stat_d = host_stat_q;
        peri_stat_d = peri_stat_q;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (st_q)
            OPC_IDLE: begin
                if (host_auto && se0_seen) begin
                    st_d = OPC_WAIT;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(1);
                end else if (peri_auto && !line_q[PU_ONE_POS]) begin
                    st_d = OPC_WAIT;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(MONITOR_CYCLES);
                end
            end
            OPC_WAIT: begin
                if (!host_auto && !peri_auto) begin
                    st_d = OPC_IDLE;
                end else if (tmr_zero) begin
                    st_d = OPC_ARMED;
                end
            end
            OPC_ARMED: begin
                if (host_auto) begin
                    auto_pu_d = 1'b1;
                    host_stat_d = 1'b1;
                    st_d = OPC_DONE;
                end else if (peri_auto) begin
                    if (dp_s2_q) begin
                        se0_d = 1'b1;
                        peri_stat_d = 1'b1;
                        st_d = OPC_DONE;
                    end
                end else begin
                    st_d = OPC_IDLE;
                end
            end
            OPC_DONE: begin
                if (!host_auto && !peri_auto) begin
                    st_d = OPC_IDLE;
                end
            end
            default: st_d = OPC_IDLE;
        endcase
        if (!host_auto) begin
            auto_pu_d = 1'b0;
        end
        if (!peri_auto) begin
            se0_d = 1'b0;
        end
        if (!auto_en) begin
            host_stat_d = 1'b0;
            peri_stat_d = 1'b0;
        end
    end

    // self timed pulse: arms on the bit, ends on timer, rearms on clear
    always_comb begin
        pulse_on_d = pulse_on_q;
        pulse_used_d = pulse_used_q;
        pulse_load = 1'b0;
        if (!bus_q[TIMED_PULSE_POS]) begin
            pulse_used_d = 1'b0;
            pulse_on_d = 1'b0;
        end else if (shutdown) begin
            pulse_on_d = 1'b0;
        end else if (!pulse_used_q) begin
            pulse_used_d = 1'b1;
            pulse_on_d = 1'b1;
            pulse_load = 1'b1;
        end else if (pulse_zero) begin
            pulse_on_d = 1'b0;
        end
    end

    always_comb begin
        out_cs = !shutdown
            && (bus_q[CONT_CHARGE_POS] || pulse_on_q);
        out_cmp = !shutdown;
        out_pump = bus_q[PUMP_DRIVE_POS];
        out_dis = bus_q[DISCHARGE_POS];
        out_pup = line_q[PU_ONE_POS] || auto_pu_q;
        out_mup = line_q[PU_TWO_POS] && !out_pup;
        out_ppd = line_q[PD_PLUS_POS];
        out_mpd = line_q[PD_MINUS_POS];
        out_irq = host_stat_q && mask_q[HOST_NEG_IRQ_POS];
    end

    opc_timer #(.W(CNT_W)) u_neg_timer (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .zero_o(tmr_zero)
    );

    opc_timer #(.W(CNT_W)) u_pulse_timer (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .load_i(pulse_load),
        .value_i(CNT_W'(PULSE_CYCLES)),
        .zero_o(pulse_zero)
    );

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            line_q <= LINE_CTRL_RST;
            bus_q <= BUS_CTRL_RST;
            mask_q <= IRQ_MASK_RST;
            rdata_q <= 8'h00;
            id_s1_q <= 1'b1;
            id_s2_q <= 1'b1;
            dp_s1_q <= 1'b0;
            dp_s2_q <= 1'b0;
            dm_s1_q <= 1'b0;
            dm_s2_q <= 1'b0;
            st_q <= OPC_IDLE;
            auto_pu_q <= 1'b0;
            se0_q <= 1'b0;
            host_stat_q <= 1'b0;
            peri_stat_q <= 1'b0;
            pulse_on_q <= 1'b0;
            pulse_used_q <= 1'b0;
            role_ident_output_o <= 1'b1;
            charge_source_on_o <= 1'b0;
            comparators_on_o <= 1'b0;
            pump_drive_o <= 1'b0;
            supply_discharge_o <= 1'b0;
            plus_pullup_on_o <= 1'b0;
            minus_pullup_on_o <= 1'b0;
            plus_pulldown_on_o <= 1'b0;
            minus_pulldown_on_o <= 1'b0;
            bus_reset_drive_o <= 1'b0;
            host_neg_irq_o <= 1'b0;
        end else begin
            line_q <= line_d;
            bus_q <= bus_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            id_s1_q <= role_ident_input_i;
            id_s2_q <= id_s1_q;
            dp_s1_q <= dp_level_i;
            dp_s2_q <= dp_s1_q;
            dm_s1_q <= dm_level_i;
            dm_s2_q <= dm_s1_q;
            st_q <= st_d;
            auto_pu_q <= auto_pu_d;
            se0_q <= se0_d;
            host_stat_q <= host_stat_d;
            peri_stat_q <= peri_stat_d;
            pulse_on_q <= pulse_on_d;
            pulse_used_q <= pulse_used_d;
            role_ident_output_o <= id_s2_q;
            charge_source_on_o <= out_cs;
            comparators_on_o <= out_cmp;
            pump_drive_o <= out_pump;
            supply_discharge_o <= out_dis;
            plus_pullup_on_o <= out_pup;
            minus_pullup_on_o <= out_mup;
            plus_pulldown_on_o <= out_ppd;
            minus_pulldown_on_o <= out_mpd;
            bus_reset_drive_o <= se0_q;
            host_neg_irq_o <= out_irq;
        end
    end

    assign reg_rdata_o = rdata_q;

    a_shutdown_off: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i) shutdown |=> !charge_source_on_o
        && !comparators_on_o)
        else $error("charger on in shutdown");
    a_no_auto_shutdown_bit: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i) shutdown |-> ##2 !bus_reset_drive_o
        || !shutdown)
        else $error("auto reset during shutdown");
    a_pullup_prio: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i)
        !(plus_pullup_on_o && minus_pullup_on_o))
        else $error("both pullups on");
    a_cont_charge: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i) (bus_q[CONT_CHARGE_POS] && !shutdown)
        |=> charge_source_on_o)
        else $error("continuous charge missing");
    a_host_drop: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i) !auto_en |-> ##2 !auto_pu_q)
        else $error("auto pullup kept");
    a_peri_stop: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i) (!auto_en && !$past(auto_en))
        |=> !bus_reset_drive_o)
        else $error("bus reset kept");
    a_connect_time: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i) (st_q == OPC_IDLE && host_auto && se0_seen)
        ##1 host_auto [*4] |-> auto_pu_q)
        else $error("autoconnect late");
    a_pulse_once: assert property (@(posedge core_clk_i)
        disable iff (!arst_n_i) ($fell(pulse_on_q) && bus_q[TIMED_PULSE_POS]
        && !shutdown) |=> !pulse_on_q)
        else $error("pulse repeated");
    c_autoconnect: cover property (@(posedge core_clk_i)
        disable iff (!arst_n_i) $rose(host_stat_q));
    c_autoresponse: cover property (@(posedge core_clk_i)
        disable iff (!arst_n_i) $rose(peri_stat_q));
    c_pulse_end: cover property (@(posedge core_clk_i)
        disable iff (!arst_n_i) $fell(pulse_on_q));
endmodule

/* verification/opc_peer.sv */
// usb peer model that sets the d+ and d- line levels
`timescale 1ns/1ps
module opc_peer (
    input wire logic attach_i,
    input wire logic dev_plus_pu_i,
    input wire logic dev_minus_pu_i,
    input wire logic se0_drive_i,
    output logic dp_level_o,
    output logic dm_level_o
);
    // a released line falls to its pulldown, se0 drive beats any pullup
    assign dp_level_o = ~se0_drive_i
        & (attach_i | dev_plus_pu_i);
    assign dm_level_o = ~se0_drive_i & dev_minus_pu_i;
endmodule

/* verification/tb_opc_core.sv */
// self-checking bench for the otg power and pullup control block
`timescale 1ns/1ps
module tb_opc_core;
    import opc_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] rdata;
    logic ident_in = 1'b1;
    logic attach = 1'b1;
    logic dp, dm, ident_out, chg, cmp, pump, dis;
    logic ppu, mpu, ppd, mpd, se0, irq;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    opc_core #(.PULSE_CYCLES(50), .MONITOR_CYCLES(5)) u_opc_core (
        .core_clk_i(core_clk),
        .arst_n_i(arst_n),
        .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata),
        .reg_rdata_o(rdata),
        .role_ident_input_i(ident_in),
        .dp_level_i(dp),
        .dm_level_i(dm),
        .role_ident_output_o(ident_out),
        .charge_source_on_o(chg),
        .comparators_on_o(cmp),
        .pump_drive_o(pump),
        .supply_discharge_o(dis),
        .plus_pullup_on_o(ppu),
        .minus_pullup_on_o(mpu),
        .plus_pulldown_on_o(ppd),
        .minus_pulldown_on_o(mpd),
        .bus_reset_drive_o(se0),
        .host_neg_irq_o(irq)
    );
    opc_peer u_opc_peer (
        .attach_i(attach),
        .dev_plus_pu_i(ppu),
        .dev_minus_pu_i(mpu),
        .se0_drive_i(se0),
        .dp_level_o(dp),
        .dm_level_o(dm)
    );
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        tick(2);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = rdata;
    endtask
    function automatic logic [7:0] outs();
        return {ppu, mpu, ppd, mpd, chg, cmp, pump, dis};
    endfunction
    task automatic t_reset();
        logic [7:0] d;
        chk("outputs", 8'h04, outs());
        rd(LINE_CTRL_ADDR, d);
        chk("line reg", LINE_CTRL_RST, d);
        rd(BUS_CTRL_ADDR, d);
        chk("bus reg", BUS_CTRL_RST, d);
        rd(IRQ_MASK_ADDR, d);
        chk("mask reg", IRQ_MASK_RST, d);
        rd(8'h3C, d);
        chk("unmapped", 8'h00, d);
        wr(STATUS_ADDR, 8'hFF);
        rd(STATUS_ADDR, d);
        chk("status ro", 8'h08, d);
        $display("test reset done");
    endtask
    task automatic t_power();
        logic [7:0] d;
        wr(BUS_CTRL_ADDR, 8'h04);
        chk("charge", 8'h0C, outs());
        wr(BUS_CTRL_ADDR, 8'h18);
        chk("pump dis", 8'h07, outs());
        wr(BUS_CTRL_ADDR, 8'h05);
        chk("shutdown", 8'h00, outs());
        rd(BUS_CTRL_ADDR, d);
        chk("bus in sd", 8'h05, d);
        ident_in = 1'b0;
        tick(5);
        chk("ident sd", 8'h00, {7'h00, ident_out});
        ident_in = 1'b1;
        tick(5);
        chk("ident sd", 8'h01, {7'h00, ident_out});
        wr(BUS_CTRL_ADDR, 8'h04);
        chk("wake", 8'h0C, outs());
        wr(BUS_CTRL_ADDR, 8'h00);
        $display("test power done");
    endtask
    task automatic t_pulse();
        wr(BUS_CTRL_ADDR, 8'h02);
        chk("pulse on", 8'h01, {7'h00, chg});
        tick(45);
        chk("pulse mid", 8'h01, {7'h00, chg});
        tick(15);
        chk("pulse off", 8'h00, {7'h00, chg});
        tick(60);
        chk("no repeat", 8'h00, {7'h00, chg});
        wr(BUS_CTRL_ADDR, 8'h00);
        wr(BUS_CTRL_ADDR, 8'h02);
        chk("re-pulse", 8'h01, {7'h00, chg});
        wr(BUS_CTRL_ADDR, 8'h03);
        chk("pulse sd", 8'h00, {7'h00, chg});
        wr(BUS_CTRL_ADDR, 8'h00);
        $display("test pulse done");
    endtask
    task automatic t_lines();
        wr(LINE_CTRL_ADDR, 8'hF0);
        chk("all sw", 8'hB4, outs());
        wr(LINE_CTRL_ADDR, 8'h60);
        chk("minus pu", 8'h64, outs());
        wr(LINE_CTRL_ADDR, 8'h80);
        chk("minus pd", 8'h14, outs());
        wr(LINE_CTRL_ADDR, 8'h00);
        $display("test lines done");
    endtask
    task automatic t_autoconnect();
        logic [7:0] d;
        ident_in = 1'b0;
        attach = 1'b0;
        wr(BUS_CTRL_ADDR, 8'h21);
        tick(30);
        chk("sd no conn", 8'h00, {7'h00, ppu});
        wr(IRQ_MASK_ADDR, 8'h10);
        wr(BUS_CTRL_ADDR, 8'h20);
        for (int i = 0; i < 20 && ppu !== 1'b1; i++) tick(1);
        chk("auto pu", 8'h01, {7'h00, ppu});
        rd(STATUS_ADDR, d);
        chk("host stat", 8'h10, d & 8'h38);
        chk("irq", 8'h01, {7'h00, irq});
        wr(LINE_CTRL_ADDR, 8'h10);
        wr(BUS_CTRL_ADDR, 8'h00);
        chk("kept pu", 8'h01, {7'h00, ppu});
        wr(LINE_CTRL_ADDR, 8'h00);
        wr(BUS_CTRL_ADDR, 8'h20);
        for (int i = 0; i < 20 && ppu !== 1'b1; i++) tick(1);
        chk("re-conn", 8'h01, {7'h00, ppu});
        wr(BUS_CTRL_ADDR, 8'h00);
        chk("drop pu", 8'h00, {6'h00, ppu, irq});
        $display("test autoconnect done");
    endtask
    task automatic t_autoresponse();
        logic [7:0] d;
        ident_in = 1'b1;
        tick(5);
        wr(BUS_CTRL_ADDR, 8'h21);
        attach = 1'b1;
        tick(30);
        chk("sd no rst", 8'h00, {7'h00, se0});
        attach = 1'b0;
        wr(BUS_CTRL_ADDR, 8'h20);
        tick(20);
        chk("idle", 8'h00, {7'h00, se0});
        attach = 1'b1;
        for (int i = 0; i < 20 && se0 !== 1'b1; i++) tick(1);
        chk("bus rst", 8'h01, {7'h00, se0});
        rd(STATUS_ADDR, d);
        chk("peri stat", 8'h28, d & 8'h38);
        wr(BUS_CTRL_ADDR, 8'h00);
        chk("rst off", 8'h00, {7'h00, se0});
        $display("test autoresponse done");
    endtask
    initial begin
        tick(12);
        arst_n = 1'b1;
        tick(1);
        t_reset();
        t_power();
        t_pulse();
        t_lines();
        t_autoconnect();
        t_autoresponse();
        finish_test();
    end
endmodule
